// ---- addr_gen_pkg.sv ----
// Purpose: Constants and carrier types for the operand address generator.
// Assumes: 16-bit data space, 8-bit general registers in four banks.
// Notes:   Mode codes are one-hot.
package addr_gen_pkg;
   localparam logic [15:0] SHORT_BASE_LOW   = 16'hFE00;
   localparam logic [7:0]  SHORT_WRAP_LIMIT = 8'h1F;
   localparam logic [7:0]  SFR_PAGE         = 8'hFF;
   localparam logic [7:0]  SFR_HOLE_LOW     = 8'hD0;
   localparam logic [7:0]  SFR_HOLE_HIGH    = 8'hDF;
   localparam logic [15:0] HSRAM_LOW        = 16'hFE00;
   localparam logic [15:0] HSRAM_HIGH       = 16'hFEFF;
   localparam logic [15:0] SHORT_WIN_LOW    = 16'hFE20;
   localparam logic [15:0] SHORT_WIN_HIGH   = 16'hFF1F;
   localparam int          SHORT_BIT8       = 8;

   typedef enum logic [5:0] {
      MODE_SHORT    = 6'h01,
      MODE_SFR      = 6'h02,
      MODE_INDIRECT = 6'h04,
      MODE_BASED    = 6'h08,
      MODE_INDEXED  = 6'h10,
      MODE_STACK    = 6'h20
   } addr_mode_t;

   // One bank of general registers as eight bytes.
   typedef struct packed {
      logic [7:0] h;
      logic [7:0] l;
      logic [7:0] d;
      logic [7:0] e;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] a;
      logic [7:0] x;
   } reg_bank_t;

   typedef struct packed {
      addr_mode_t mode;
      logic [7:0] imm;
      logic       use_second_pair;
      logic       index_high;
      logic       wide;
      logic       stack_op;
   } addr_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic        fault;
   } addr_rsp_t;
endpackage

// ---- mem_space_model.sv ----
// Purpose: Far-side memory map that flags high-speed RAM hits.
// Assumes: One access per valid cycle.
// Notes:   Only the RAM region flag is modelled.
`timescale 1ns/10ps
`default_nettype none
module mem_space_model (
   input  wire logic        clk_in,
   input  wire logic        addr_valid_in,
   input  wire logic [15:0] addr_in,
   output logic             hsram_hit_out
);
   always_ff @(posedge clk_in) begin
      hsram_hit_out <= addr_valid_in && addr_in[15:8] == 8'hFE;
   end
endmodule
`default_nettype wire

// ---- operand_address_generator.sv ----
// Purpose: Forms operand effective addresses for the core each clock.
// Assumes: Request is a level valid for one cycle; answer follows one edge later.
// Notes:   Illegal SFR/stack targets raise fault and suppress valid.
//
// Summary of operation
// - Short direct bit 8 set for 00H-1FH only.
// - Short direct spans FE20H through FF1FH.
// - SFR mode reaches FF00H-FFCFH and FFE0H-FFFFH.
// - FF00H-FF1FH reachable by short direct too.
// - Wide SFR operands need even addresses.
// - Indirect uses selected bank pointer pair.
// - Based adds zero-extended byte, carry dropped.
// - Based indexed adds B or C, carry dropped.
// - Pointer modes reach the whole space.
// - Stack accesses address from stack pointer.
// - Stack confined to internal high-speed RAM.
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator
   import addr_gen_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             req_valid_in,
   input  wire addr_req_t        req_in,
   input  wire logic             bank_select_bit_low_in,
   input  wire logic             bank_select_bit_high_in,
   input  wire reg_bank_t [3:0]  banks_in,
   input  wire logic [15:0]      stack_top_pointer_in,
   output logic                  addr_valid_out,
   output logic [15:0]           addr_out,
   output logic                  addr_fault_out,
   output logic                  stack_access_out
);
   wire logic [1:0]  bank_sel;
   wire reg_bank_t   bank;
   wire logic [15:0] base_pointer_pair;
   wire logic [15:0] second_pointer_pair;
   wire logic [15:0] short_addr;
   wire logic [15:0] sfr_addr;
   wire logic [15:0] based_addr;
   wire logic [15:0] indexed_addr;
   wire logic [7:0]  index_byte;
   wire logic        sfr_bad;
   wire logic        stack_bad;
   logic [15:0]      addr_nxt;
   logic             fault_nxt;

   assign bank_sel            = {bank_select_bit_high_in, bank_select_bit_low_in};
   assign bank                = banks_in[bank_sel];
   assign base_pointer_pair   = {bank.h, bank.l};
   assign second_pointer_pair = {bank.d, bank.e};
   // Upper byte FE or FF chosen by wrap, which also makes FF00H-FF1FH short-reachable.
   assign short_addr = SHORT_BASE_LOW | {7'h00, (req_in.imm <= SHORT_WRAP_LIMIT),
                                        req_in.imm};
   assign sfr_addr   = {SFR_PAGE, req_in.imm};
   assign sfr_bad    = ((req_in.imm >= SFR_HOLE_LOW) && (req_in.imm <= SFR_HOLE_HIGH))
                       || (req_in.wide && req_in.imm[0]);
   // Sixteen-bit sums wrap naturally, so the carry is simply lost.
   assign based_addr   = base_pointer_pair + {8'h00, req_in.imm};
   assign index_byte   = req_in.index_high ? bank.b : bank.c;
   assign indexed_addr = base_pointer_pair + {8'h00, index_byte};
   assign stack_bad    = (stack_top_pointer_in < HSRAM_LOW)
                         || (stack_top_pointer_in > HSRAM_HIGH);

   always_comb begin
      addr_nxt  = 16'h0000;
      fault_nxt = 1'b0;
      case (req_in.mode)
         MODE_SHORT:    addr_nxt = short_addr;
         MODE_SFR: begin
            addr_nxt  = sfr_addr;
            fault_nxt = sfr_bad;
         end
         MODE_INDIRECT: addr_nxt = req_in.use_second_pair ? second_pointer_pair
                                                          : base_pointer_pair;
         MODE_BASED:    addr_nxt = based_addr;
         MODE_INDEXED:  addr_nxt = indexed_addr;
         MODE_STACK: begin
            addr_nxt  = stack_top_pointer_in;
            fault_nxt = stack_bad;
         end
         default:       fault_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         addr_valid_out   <= 1'b0;
         addr_out         <= 16'h0000;
         addr_fault_out   <= 1'b0;
         stack_access_out <= 1'b0;
      end else begin
         addr_valid_out   <= req_valid_in && !fault_nxt;
         addr_out         <= addr_nxt;
         addr_fault_out   <= req_valid_in && fault_nxt;
         stack_access_out <= req_valid_in && (req_in.mode == MODE_STACK);
      end
   end

   short_bit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SHORT |=>
         addr_out[SHORT_BIT8] == ($past(req_in.imm) <= SHORT_WRAP_LIMIT))
      else $error("short direct bit 8 wrong");
   short_range_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SHORT |=>
         addr_valid_out && addr_out >= SHORT_WIN_LOW && addr_out <= SHORT_WIN_HIGH)
      else $error("short direct outside window");
   sfr_hole_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      addr_valid_out && $past(req_in.mode) == MODE_SFR |->
         !(addr_out >= {SFR_PAGE, SFR_HOLE_LOW} && addr_out <= {SFR_PAGE, SFR_HOLE_HIGH}))
      else $error("sfr hole reached");
   short_sfr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SHORT && req_in.imm <= SHORT_WRAP_LIMIT |=>
         addr_out[15:8] == SFR_PAGE && addr_valid_out)
      else $error("low sfr not short reachable");
   sfr_even_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SFR && req_in.wide && req_in.imm[0] |=>
         addr_fault_out && !addr_valid_out)
      else $error("odd wide sfr accepted");
   sfr_form_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SFR |=>
         addr_out == {SFR_PAGE, $past(req_in.imm)})
      else $error("sfr address malformed");
   based_sum_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_BASED |=>
         addr_out == 16'($past(base_pointer_pair) + {8'h00, $past(req_in.imm)}))
      else $error("based sum wrong");
   indexed_sum_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_INDEXED |=>
         addr_out == 16'($past(base_pointer_pair) + {8'h00, $past(index_byte)}))
      else $error("indexed sum wrong");
   indirect_pair_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_INDIRECT |=> addr_valid_out &&
         addr_out == ($past(req_in.use_second_pair) ? $past(second_pointer_pair)
                                                     : $past(base_pointer_pair)))
      else $error("indirect pair wrong");
   stack_ram_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      addr_valid_out && stack_access_out |->
         addr_out == $past(stack_top_pointer_in) && addr_out >= HSRAM_LOW
         && addr_out <= HSRAM_HIGH)
      else $error("stack outside high-speed ram");

   // Bank taken straight from the flags, so the checks below do not lean on bank_sel.
   wire logic [1:0]  flag_bank;
   assign flag_bank = {bank_select_bit_high_in, bank_select_bit_low_in};

   // Valid and fault are the two ways a request is answered; both at once would
   // let the memory act on an address that the core has already refused.
   answer_excl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !(addr_valid_out && addr_fault_out))
      else $error("valid and fault together");

   short_page_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SHORT && req_in.imm > SHORT_WRAP_LIMIT |=>
         addr_out == {HSRAM_LOW[15:8], $past(req_in.imm)})
      else $error("short direct page wrong");

   // Each answer is one edge behind its request, so the checks are built from
   // a request step and an answer step.
   sequence sfr_legal_req_s;
      req_valid_in && req_in.mode == MODE_SFR && !(req_in.wide && req_in.imm[0])
         && (req_in.imm < SFR_HOLE_LOW || req_in.imm > SFR_HOLE_HIGH);
   endsequence

   sequence stack_req_s;
      req_valid_in && req_in.mode == MODE_STACK;
   endsequence

   sequence accepted_s;
      addr_valid_out && !addr_fault_out;
   endsequence

   sequence refused_s;
      addr_fault_out && !addr_valid_out;
   endsequence

   short_accept_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SHORT |=> accepted_s)
      else $error("short direct refused");

   sfr_legal_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sfr_legal_req_s |=> accepted_s)
      else $error("legal sfr refused");

   sfr_gap_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_SFR && req_in.imm >= SFR_HOLE_LOW
         && req_in.imm <= SFR_HOLE_HIGH |=> refused_s)
      else $error("sfr gap accepted");

   // The stack flag marks every stack answer, refused ones too, so that the core
   // can tell a bad stack pointer from a bad operand.
   stack_flag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      stack_req_s |=> stack_access_out && (addr_valid_out || addr_fault_out))
      else $error("stack answer unflagged");

   stack_only_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      stack_access_out |-> $past(req_valid_in) && $past(req_in.mode) == MODE_STACK)
      else $error("stack flag without stack request");

   stack_accept_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      stack_req_s ##0 (stack_top_pointer_in >= HSRAM_LOW
         && stack_top_pointer_in <= HSRAM_HIGH) |=> accepted_s)
      else $error("legal stack access refused");

   stack_bound_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      stack_req_s ##0 (stack_top_pointer_in < HSRAM_LOW
         || stack_top_pointer_in > HSRAM_HIGH) |=> refused_s)
      else $error("stack outside ram accepted");

   // Pointer modes have no range limit, so nothing but the mode may refuse them.
   pointer_free_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && (req_in.mode == MODE_INDIRECT || req_in.mode == MODE_BASED
         || req_in.mode == MODE_INDEXED) |=> accepted_s)
      else $error("pointer mode refused");

   bank_pick_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_INDIRECT && req_in.use_second_pair |=>
         addr_out == {$past(banks_in[flag_bank].d), $past(banks_in[flag_bank].e)})
      else $error("pointer pair from wrong bank");

   index_pick_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      req_valid_in && req_in.mode == MODE_INDEXED && req_in.index_high |=>
         addr_out == 16'({$past(banks_in[flag_bank].h), $past(banks_in[flag_bank].l)}
                         + {8'h00, $past(banks_in[flag_bank].b)}))
      else $error("high index from wrong bank");
endmodule
`default_nettype wire

// ---- operand_address_generator_tb.sv ----
// Purpose: Self-checking bench for the operand address generator.
// Assumes: Each answer comes one cycle after its request.
// Notes:   Legal modes only; faults come from SFR hole, odd wide SFR, stack.
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator_tb;
   import addr_gen_pkg::*;
   logic            clk_in = 0, sys_rst_in = 1, req_valid_in = 0, bank_lo = 0, bank_hi = 0;
   addr_req_t       req_in = '0;
   reg_bank_t [3:0] banks_in = '0, bk;
   logic [15:0]     stack_ptr = 16'h0000, addr_out;
   logic            addr_valid_out, addr_fault_out, stack_access_out, ram_hit, stack_prev = 0;
   logic [18:0]     exp_q[$], e;
   int              num_errors = 0, n_compared = 0, cyc = 0;
   logic [31:0]     seed = 22994;
   addr_mode_t      modes[6] = '{MODE_SHORT, MODE_SFR, MODE_INDIRECT, MODE_BASED,
                                 MODE_INDEXED, MODE_STACK};
   logic [7:0]      imms[9] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'hCF, 8'hD0, 8'hDF, 8'hE0, 8'hFF};
   operand_address_generator i_operand_address_generator (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
      .bank_select_bit_low_in(bank_lo), .bank_select_bit_high_in(bank_hi),
      .banks_in(banks_in), .stack_top_pointer_in(stack_ptr), .addr_valid_out(addr_valid_out),
      .addr_out(addr_out), .addr_fault_out(addr_fault_out), .stack_access_out(stack_access_out));
   mem_space_model i_mem_space_model (.clk_in(clk_in), .addr_valid_in(addr_valid_out),
      .addr_in(addr_out), .hsram_hit_out(ram_hit));
   initial forever #20 clk_in = ~clk_in;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected word is {valid, fault, stack, address}.
   function automatic logic [18:0] expect_of(addr_req_t r, reg_bank_t b, logic [15:0] s);
      logic [15:0] ptr;
      logic        f;
      ptr = {b.h, b.l};
      f = (r.imm[7:4] == 4'hD) | (r.wide & r.imm[0]);
      case (r.mode)
         MODE_SHORT: return {3'b100, 8'hFE + (r.imm < 8'h20), r.imm};
         MODE_SFR: return {~f, f, 1'b0, 8'hFF, r.imm};
         MODE_INDIRECT: return {3'b100, r.use_second_pair ? {b.d, b.e} : ptr};
         MODE_BASED: return {3'b100, ptr + {8'h00, r.imm}};
         MODE_INDEXED: return {3'b100, ptr + {8'h00, r.index_high ? b.b : b.c}};
         default: return {s[15:8] == 8'hFE, s[15:8] != 8'hFE, 1'b1, s};
      endcase
   endfunction
   task automatic check(string what, logic [18:0] exp, logic [18:0] got);
      n_compared++;
      if (exp !== got) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic go(addr_req_t r, reg_bank_t [3:0] b, logic [1:0] k, logic [15:0] s);
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_in <= r;
      banks_in <= b;
      {bank_hi, bank_lo} <= k;
      stack_ptr <= s;
      exp_q.push_back(expect_of(r, b[k], s));
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(negedge clk_in) begin
      if (stack_prev) check("stack ram hit", 19'h1, {18'h0, ram_hit});
      stack_prev = (addr_valid_out & stack_access_out) === 1'b1;
      if ((addr_valid_out | addr_fault_out) === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
         check("answer", e, {addr_valid_out, addr_fault_out, stack_access_out,
                             addr_out});
      end
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      logic [31:0] t;
      addr_req_t   r;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      // All-ones banks force the pointer sums to wrap past FFFFH for every nonzero offset.
      for (int m = 0; m < 6; m++) foreach (imms[i]) for (int w = 0; w < 2; w++) begin
         r = '{modes[m], imms[i], w[0], w[0], w[0], 1'b0};
         go(r, '1, w[1:0], w[0] ? 16'hFF00 : 16'hFE10);
      end
      $display("boundary test done");
      // A reset between the runs, once the last boundary answer is out, must bring no stray answer.
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      sys_rst_in   <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in   <= 1'b0;
      repeat (600) begin
         t = rnd();
         r = addr_req_t'(t[17:0]);
         r.mode = modes[t[31:24] % 6];
         foreach (bk[i]) bk[i] = {rnd(), rnd()};
         go(r, bk, t[21:20], {t[23] ? 8'hFE : t[31:24], t[15:8]});
      end
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("pending", 19'h0, 19'(exp_q.size()));
      $display("random test done");
      results();
   end
endmodule
`default_nettype wire
